// *** hw/srid_decoder.sv ***
// Summary of operation
// - Torque select low: forward and reverse torque limit parameters are active.
// - Torque select high: internal torque limit parameter replaces both limits.
// - Proportional bit high: speed loop runs proportional only, else PI.
// - Gain change bit high: alternate inertia ratio and gain set is used.
// - Specifying select low: command comes from table entry picked by five bits.
// - Specifying select high: command from command registers, direct code register-based.
// - Absolute/incremental bit honoured only with register mode and absolute system.
// - Honoured bit low means absolute target, high means incremental move.
// - Alarm clears after reset bit held 50 ms; bit position depends on occupancy.
// - Non-clearable alarm types stay active despite reset bit.
// - Reset with no alarm keeps power stage on unless shutoff code set.
// - Forced stop comes only from the hard-wired input, no fieldbus bit.
// - Forced stop input off: enter stop state, power off, dynamic brake on.
// - Forced stop input back on: leave the stop state.
`timescale 1ns/1ps
`include "srid_map.svh"
module srid_decoder #(
    parameter int HOLD_CYC = `SRID_RESET_HOLD_MS * `SRID_CLK_KHZ
) (
    // Clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_i,
    // AXI4-Lite slave
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Image refresh and hard-wired input
    input  wire logic                 image_refresh_i,
    input  wire logic                 forced_stop_input_i,
    // Servo core side
    input  wire logic                 alarm_active_i,
    input  wire logic                 alarm_clearable_i,
    output srid_pkg::srid_torque_t    torque_limit_o,
    output srid_pkg::srid_cmd_t       command_o,
    output srid_pkg::srid_drive_t     drive_o,
    output logic                      alarm_clear_o,
    output logic                      irq_o
);
    import srid_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a <= `SRID_OFS_IRQ_MASK && a[1:0] == 2'b00;
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0]             image_lo_q, image_hi_q, config_q, torque_q, int_torque_q;
    logic [31:0]             cmd_pos_q, cmd_spd_q;
    logic [`SRID_IRQ_W-1:0]  irq_stat_q, irq_mask_q;
    srid_state_t             state_q;
    logic [23:0]             hold_cnt_q;
    logic                    reset_held_q;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire        wr_take  = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    wire        wr_fire  = s_axi_awready;
    wire        rd_take  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    wire        rd_fire  = s_axi_arready;
    wire [7:0]  wa       = s_axi_awaddr;
    wire [7:0]  ra       = s_axi_araddr;
    wire        wr_lo    = wr_fire && wa == `SRID_OFS_IMAGE_LO;
    wire        wr_hi    = wr_fire && wa == `SRID_OFS_IMAGE_HI;
    wire        wr_cfg   = wr_fire && wa == `SRID_OFS_CONFIG;
    wire        wr_tq    = wr_fire && wa == `SRID_OFS_TORQUE;
    wire        wr_itq   = wr_fire && wa == `SRID_OFS_INT_TORQUE;
    wire        wr_pos   = wr_fire && wa == `SRID_OFS_CMD_POS;
    wire        wr_spd   = wr_fire && wa == `SRID_OFS_CMD_SPD;
    wire        wr_msk   = wr_fire && wa == `SRID_OFS_IRQ_MASK;
    wire        rd_irq   = rd_fire && ra == `SRID_OFS_IRQ_STAT;

    // ----------------------------------------
    // Remote image decode
    // ----------------------------------------
    wire        two_station = config_q[`SRID_BIT_TWO_STATION];
    wire        cmd_abs_sys = config_q[`SRID_BIT_CMD_ABS];
    wire        shutoff_cfg = config_q[`SRID_BIT_SHUTOFF];
    wire [3:0]  direct_code = config_q[`SRID_FLD_DIRECT_HI:`SRID_FLD_DIRECT_LO];
    // The reset bit moves with station occupancy
    wire        reset_bit   = two_station ? image_hi_q[`SRID_BIT_RESET]
                                          : image_lo_q[`SRID_BIT_RESET];
    wire        torque_sel  = image_hi_q[`SRID_BIT_TORQUE_SEL];
    wire        spec_sel    = image_hi_q[`SRID_BIT_SPEC_SEL];
    // Register mode needs the direct code too, else the table stays in charge
    wire        reg_mode    = spec_sel && direct_code == `SRID_DIRECT_REG_CODE;
    wire        incr_honour = reg_mode && cmd_abs_sys;

    srid_torque_t torque_d;
    srid_cmd_t    cmd_d;
    assign torque_d.fwd = torque_sel ? int_torque_q[15:0] : torque_q[15:0];
    assign torque_d.rev = torque_sel ? int_torque_q[15:0] : torque_q[31:16];
    assign cmd_d.from_regs   = reg_mode;
    assign cmd_d.incremental = incr_honour && image_hi_q[`SRID_BIT_ABS_INC];
    assign cmd_d.table_index = image_lo_q[`SRID_BIT_TABLE_HI:`SRID_BIT_TABLE_LO];
    assign cmd_d.position    = cmd_pos_q;
    assign cmd_d.speed       = cmd_spd_q;

    // ----------------------------------------
    // Alarm reset and forced stop
    // ----------------------------------------
    wire        hold_done   = hold_cnt_q == 24'(HOLD_CYC - 1);
    wire        clear_d     = hold_done && reset_bit && alarm_active_i && alarm_clearable_i;
    // Only the hard-wired pin feeds the stop state; no image bit reaches it
    wire        fstop_enter = state_q == SRID_RUN && !forced_stop_input_i;
    wire        fstop_leave = state_q == SRID_FSTOP && forced_stop_input_i;
    wire        in_fstop    = state_q == SRID_FSTOP || fstop_enter;
    wire [`SRID_IRQ_W-1:0] irq_ev = {clear_d, fstop_leave, fstop_enter};
    wire        power_d     = !in_fstop && !alarm_active_i
                            && !(reset_held_q && shutoff_cfg);

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SRID_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `SRID_RESP_OKAY;
            s_axi_rdata   <= `SRID_RST_WORD;
        end else begin
            s_axi_awready <= wr_take;
            s_axi_wready  <= wr_take;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wa) ? `SRID_RESP_OKAY : `SRID_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= rd_take;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= mapped(ra) ? `SRID_RESP_OKAY : `SRID_RESP_SLVERR;
                unique case (ra)
                    `SRID_OFS_IMAGE_LO:   s_axi_rdata <= image_lo_q;
                    `SRID_OFS_IMAGE_HI:   s_axi_rdata <= image_hi_q;
                    `SRID_OFS_CONFIG:     s_axi_rdata <= config_q;
                    `SRID_OFS_TORQUE:     s_axi_rdata <= torque_q;
                    `SRID_OFS_INT_TORQUE: s_axi_rdata <= int_torque_q;
                    `SRID_OFS_CMD_POS:    s_axi_rdata <= cmd_pos_q;
                    `SRID_OFS_CMD_SPD:    s_axi_rdata <= cmd_spd_q;
                    `SRID_OFS_STATUS:     s_axi_rdata <= {26'h0, reset_held_q, drive_o};
                    `SRID_OFS_IRQ_STAT:   s_axi_rdata <= {29'h0, irq_stat_q};
                    `SRID_OFS_IRQ_MASK:   s_axi_rdata <= {29'h0, irq_mask_q};
                    default:              s_axi_rdata <= `SRID_RST_WORD;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            image_lo_q   <= `SRID_RST_WORD;
            image_hi_q   <= `SRID_RST_WORD;
            config_q     <= `SRID_RST_CONFIG;
            torque_q     <= `SRID_RST_WORD;
            int_torque_q <= `SRID_RST_WORD;
            cmd_pos_q    <= `SRID_RST_WORD;
            cmd_spd_q    <= `SRID_RST_WORD;
            irq_mask_q   <= '0;
        end else begin
            if (wr_lo)  image_lo_q   <= merge(image_lo_q, s_axi_wdata, s_axi_wstrb);
            if (wr_hi)  image_hi_q   <= merge(image_hi_q, s_axi_wdata, s_axi_wstrb);
            if (wr_cfg) config_q     <= merge(config_q, s_axi_wdata, s_axi_wstrb);
            if (wr_tq)  torque_q     <= merge(torque_q, s_axi_wdata, s_axi_wstrb);
            if (wr_itq) int_torque_q <= merge(int_torque_q, s_axi_wdata, s_axi_wstrb);
            if (wr_pos) cmd_pos_q    <= merge(cmd_pos_q, s_axi_wdata, s_axi_wstrb);
            if (wr_spd) cmd_spd_q    <= merge(cmd_spd_q, s_axi_wdata, s_axi_wstrb);
            if (wr_msk) irq_mask_q   <= s_axi_wdata[`SRID_IRQ_W-1:0];
        end
    end

    // ----------------------------------------
    // Refresh-sampled mode outputs
    // ----------------------------------------
    // Mode outputs follow levels only at a refresh, so a half-written image never leaks into them; the reset bit acts every cycle
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            torque_limit_o     <= '0;
            command_o          <= '0;
            drive_o.prop_mode  <= 1'b0;
            drive_o.gain_alt   <= 1'b0;
        end else if (image_refresh_i) begin
            torque_limit_o     <= torque_d;
            command_o          <= cmd_d;
            drive_o.prop_mode  <= image_hi_q[`SRID_BIT_PROP];
            drive_o.gain_alt   <= image_hi_q[`SRID_BIT_GAIN];
        end
    end

    // ----------------------------------------
    // Alarm reset timer, stop state, interrupts
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hold_cnt_q           <= '0;
            reset_held_q         <= 1'b0;
            alarm_clear_o        <= 1'b0;
            state_q              <= SRID_FSTOP;
            drive_o.power_enable <= 1'b0;
            drive_o.dyn_brake    <= 1'b1;
            drive_o.forced_stop  <= 1'b1;
            irq_stat_q           <= '0;
            irq_o                <= 1'b0;
        end else begin
            // Any drop of the bit restarts the count
            if (!reset_bit) begin
                hold_cnt_q <= '0;
            end else if (!hold_done) begin
                hold_cnt_q <= hold_cnt_q + 24'h1;
            end
            reset_held_q         <= reset_bit;
            alarm_clear_o        <= clear_d;
            if (fstop_enter) state_q <= SRID_FSTOP;
            else if (fstop_leave) state_q <= SRID_RUN;
            drive_o.power_enable <= power_d;
            drive_o.dyn_brake    <= in_fstop;
            drive_o.forced_stop  <= in_fstop;
            // A new event wins over the clear of a status read
            irq_stat_q           <= (rd_irq ? '0 : irq_stat_q) | irq_ev;
            irq_o                <= |(((rd_irq ? '0 : irq_stat_q) | irq_ev) & irq_mask_q);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    fwd_torque_src_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        image_refresh_i && !torque_sel |=> torque_limit_o.fwd == $past(torque_q[15:0]))
        else $error("forward limit not from forward parameter");

    int_torque_src_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        image_refresh_i && torque_sel |=> torque_limit_o.rev == $past(int_torque_q[15:0]))
        else $error("reverse limit not from internal parameter");

    prop_mode_follow_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        image_refresh_i |=> drive_o.prop_mode == $past(image_hi_q[`SRID_BIT_PROP]))
        else $error("proportional mode does not follow image");

    gain_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !image_refresh_i |=> $stable(drive_o.gain_alt))
        else $error("gain set changed without refresh");

    table_mode_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        image_refresh_i && !spec_sel |=> !command_o.from_regs)
        else $error("register mode without specifying select");

    table_index_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        image_refresh_i |=> command_o.table_index == $past(image_lo_q[`SRID_BIT_TABLE_HI:`SRID_BIT_TABLE_LO]))
        else $error("table index does not follow image");

    spec_reg_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        image_refresh_i && reg_mode |=> command_o.from_regs && command_o.position == $past(cmd_pos_q))
        else $error("register command not taken");

    incr_ignored_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        image_refresh_i && !cmd_abs_sys |=> !command_o.incremental)
        else $error("incremental bit honoured without absolute system");

    incr_follow_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        image_refresh_i && incr_honour |=> command_o.incremental == $past(image_hi_q[`SRID_BIT_ABS_INC]))
        else $error("absolute or incremental choice not followed");

    alarm_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        alarm_clear_o |-> $past(reset_bit) && $past(hold_cnt_q) == 24'(HOLD_CYC - 1))
        else $error("alarm cleared before hold time");

    alarm_keep_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !alarm_clearable_i |=> !alarm_clear_o)
        else $error("designated alarm cleared");

    reset_power_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        reset_held_q && !shutoff_cfg && !alarm_active_i && !in_fstop |=> drive_o.power_enable)
        else $error("power dropped by reset bit without shutoff code");

    reset_shut_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        reset_held_q && shutoff_cfg |=> !drive_o.power_enable)
        else $error("power kept although shutoff code set");

    pin_only_stop_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_q == SRID_RUN && forced_stop_input_i |=> !drive_o.forced_stop)
        else $error("forced stop without the stop pin");

    fstop_enter_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !forced_stop_input_i |=> drive_o.dyn_brake && !drive_o.power_enable)
        else $error("forced stop not applied");

    fstop_leave_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        forced_stop_input_i [*2] |=> !drive_o.forced_stop)
        else $error("forced stop not left");

    irq_level_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        irq_o |-> $past(irq_mask_q) != '0)
        else $error("interrupt with all sources masked");

    irq_set_wins_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        irq_ev != '0 |=> (irq_stat_q & $past(irq_ev)) == $past(irq_ev))
        else $error("interrupt event lost");

    stat_read_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rd_irq && irq_ev == '0 |=> irq_stat_q == '0)
        else $error("status read did not clear");
endmodule

// *** hw/srid_map.svh ***
`ifndef SRID_MAP_SVH
`define SRID_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SRID_OFS_IMAGE_LO   8'h00
`define SRID_OFS_IMAGE_HI   8'h04
`define SRID_OFS_CONFIG     8'h08
`define SRID_OFS_TORQUE     8'h0c
`define SRID_OFS_INT_TORQUE 8'h10
`define SRID_OFS_CMD_POS    8'h14
`define SRID_OFS_CMD_SPD    8'h18
`define SRID_OFS_STATUS     8'h1c
`define SRID_OFS_IRQ_STAT   8'h20
`define SRID_OFS_IRQ_MASK   8'h24
// ----------------------------------------
// Image bit positions
// ----------------------------------------
`define SRID_BIT_TABLE_LO   10
`define SRID_BIT_TABLE_HI   14
`define SRID_BIT_RESET      26
`define SRID_BIT_TORQUE_SEL 6
`define SRID_BIT_PROP       7
`define SRID_BIT_GAIN       8
`define SRID_BIT_SPEC_SEL   10
`define SRID_BIT_ABS_INC    11
// ----------------------------------------
// Config fields
// ----------------------------------------
`define SRID_BIT_TWO_STATION 0
`define SRID_BIT_CMD_ABS     1
`define SRID_BIT_SHUTOFF     2
`define SRID_FLD_DIRECT_LO   4
`define SRID_FLD_DIRECT_HI   7
`define SRID_DIRECT_REG_CODE 4'h2
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define SRID_RST_WORD      32'h0000_0000
`define SRID_RST_CONFIG    32'h0000_0001
`define SRID_RESP_OKAY     2'b00
`define SRID_RESP_SLVERR   2'b10
`define SRID_IRQ_FSTOP_IN  0
`define SRID_IRQ_FSTOP_OUT 1
`define SRID_IRQ_ALM_CLR   2
`define SRID_IRQ_W         3
// ----------------------------------------
// Timing
// ----------------------------------------
`define SRID_CLK_KHZ       250000
`define SRID_RESET_HOLD_MS 50
`endif

// *** hw/srid_pkg.sv ***
package srid_pkg;
    typedef struct packed {
        logic [15:0] fwd;
        logic [15:0] rev;
    } srid_torque_t;

    typedef struct packed {
        logic        from_regs;
        logic        incremental;
        logic [4:0]  table_index;
        logic [31:0] position;
        logic [31:0] speed;
    } srid_cmd_t;

    typedef struct packed {
        logic prop_mode;
        logic gain_alt;
        logic power_enable;
        logic dyn_brake;
        logic forced_stop;
    } srid_drive_t;

    typedef enum logic {
        SRID_RUN,
        SRID_FSTOP
    } srid_state_t;
endpackage

// *** tb/srid_master_model.sv ***
`timescale 1ns/1ps
module srid_master_model #(
    parameter int PERIOD = 8
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    // Bench control
    input  wire logic run_i,
    input  wire logic raise_i,
    input  wire logic clearable_i,
    // Block side
    input  wire logic alarm_clear_i,
    output logic      image_refresh_o,
    output logic      alarm_active_o,
    output logic      alarm_clearable_o
);
    logic [7:0] cnt_q;
    logic       wrap;

    // ----------------------------------------
    // Cyclic image refresh
    // ----------------------------------------
    // Held off while the bench stops it, so a test can see that nothing moves between refreshes
    assign wrap = (cnt_q == 8'(PERIOD - 1));
    always_ff @(posedge core_clk_i) begin
        if (reset_i || !run_i) begin
            cnt_q           <= 8'h00;
            image_refresh_o <= 1'h0;
        end else begin
            cnt_q           <= wrap ? 8'h00 : cnt_q + 8'h01;
            image_refresh_o <= wrap;
        end
    end

    // ----------------------------------------
    // Servo core alarm
    // ----------------------------------------
    // Only a clear pulse removes a clearable alarm; other kinds stay until made clearable
    assign alarm_clearable_o = clearable_i;
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            alarm_active_o <= 1'h0;
        end else if (raise_i) begin
            alarm_active_o <= 1'h1;
        end else if (alarm_clear_i && clearable_i) begin
            alarm_active_o <= 1'h0;
        end
    end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "srid_map.svh"
module tb;
    import srid_pkg::*;
    localparam int HOLD = 16;
    localparam logic [31:0] CFG [5] = '{32'h23, 32'h21, 32'h23, 32'h13, 32'h23};
    localparam logic [31:0] IMG [5] = '{32'hc00, 32'hc00, 32'h400, 32'hc00, 32'h800};
    localparam logic [1:0]  EXP [5] = '{2'h3, 2'h2, 2'h2, 2'h0, 2'h0};
    logic         clk = 1'h0;
    logic         rst = 1'h1;
    logic [7:0]   awaddr = 8'h00;
    logic [7:0]   araddr = 8'h00;
    logic [31:0]  wdata = 32'h0;
    logic         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic         run = 1'h0, raise = 1'h0, clrok = 1'h1, pin = 1'h1;
    logic         awready, wready, bvalid, arready, rvalid, refr, alm, almok, aclr, irq, ia;
    logic [1:0]   bresp, rresp, rd_r, wr_r;
    logic [31:0]  rdata, rd_v;
    srid_torque_t tq;
    srid_cmd_t    cmd;
    srid_drive_t  drv;
    int           num_errors = 0;
    int           checks_done = 0;

    always #2 clk = ~clk;

    srid_decoder #(.HOLD_CYC(HOLD)) i_srid_decoder (
        .core_clk_i(clk), .reset_i(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .image_refresh_i(refr),
        .forced_stop_input_i(pin), .alarm_active_i(alm), .alarm_clearable_i(almok),
        .torque_limit_o(tq), .command_o(cmd), .drive_o(drv), .alarm_clear_o(aclr), .irq_o(irq));

    srid_master_model i_srid_master_model (
        .core_clk_i(clk), .reset_i(rst), .run_i(run), .raise_i(raise), .clearable_i(clrok),
        .alarm_clear_i(aclr), .image_refresh_o(refr), .alarm_active_o(alm), .alarm_clearable_o(almok));

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [70:0] exp, input logic [70:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do begin
            @(posedge clk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        wr_r = bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do begin
            @(posedge clk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        rd_v = rdata;
        rd_r = rresp;
    endtask

    // Outputs load on the same edge that sees the refresh, so read them two edges later
    task automatic sync;
        @(posedge clk iff refr);
        repeat (2) @(posedge clk);
    endtask

    task automatic wrap_up;
        $display("Checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        wrap_up;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd(`SRID_OFS_CONFIG);
        chk("config reset", `SRID_RST_CONFIG, rd_v);
        rd(8'h28);
        chk("unmapped resp", `SRID_RESP_SLVERR, rd_r);
        wr(8'h2a, 32'h0000_0000);
        chk("unaligned bresp", `SRID_RESP_SLVERR, wr_r);
        wr(`SRID_OFS_TORQUE, 32'h0022_0011);
        chk("write bresp", `SRID_RESP_OKAY, wr_r);
        wr(`SRID_OFS_INT_TORQUE, 32'h0000_0033);
        wr(`SRID_OFS_IMAGE_HI, 32'h0000_0180);
        run <= 1'h1;
        sync;
        chk("torque pair", {16'h0011, 16'h0022}, tq);
        chk("prop mode", 1'h1, drv.prop_mode);
        chk("gain alt", 1'h1, drv.gain_alt);
        run <= 1'h0;
        wr(`SRID_OFS_IMAGE_HI, 32'h0000_0040);
        repeat (10) @(posedge clk);
        chk("held prop", 1'h1, drv.prop_mode);
        run <= 1'h1;
        sync;
        chk("torque int", {16'h0033, 16'h0033}, tq);
        chk("pi mode", 1'h0, drv.prop_mode);
        chk("gain base", 1'h0, drv.gain_alt);
        wr(`SRID_OFS_IMAGE_HI, 32'h0000_00c0);
        sync;
        chk("lock torque", {16'h0033, 16'h0033}, tq);
        chk("lock prop", 1'h1, drv.prop_mode);
        wr(`SRID_OFS_CMD_POS, 32'h1234_5678);
        wr(`SRID_OFS_CMD_SPD, 32'h0000_abcd);
        wr(`SRID_OFS_IMAGE_LO, 32'hfbff_ffff);
        sync;
        chk("table mode", {2'h0, 5'h1f}, cmd[70:64]);
        chk("no bus stop", 1'h0, drv.forced_stop);
        for (int i = 0; i < 5; i++) begin
            wr(`SRID_OFS_CONFIG, CFG[i]);
            wr(`SRID_OFS_IMAGE_HI, IMG[i]);
            sync;
            chk("cmd mode", EXP[i], {cmd.from_regs, cmd.incremental});
            if (EXP[i][1]) chk("cmd pos", 32'h1234_5678, cmd.position);
            if (EXP[i][1]) chk("cmd spd", 32'h0000_abcd, cmd.speed);
        end
        wr(`SRID_OFS_CONFIG, 32'h00);
        wr(`SRID_OFS_IMAGE_LO, 32'h0400_0000);
        sync;
        repeat (HOLD + 4) @(posedge clk);
        chk("power kept", 1'h1, drv.power_enable);
        wr(`SRID_OFS_CONFIG, 32'h04);
        sync;
        chk("power shut", 1'h0, drv.power_enable);
        wr(`SRID_OFS_CONFIG, 32'h01);
        wr(`SRID_OFS_IMAGE_HI, 32'h0);
        sync;
        raise <= 1'h1;
        @(posedge clk);
        raise <= 1'h0;
        wr(`SRID_OFS_IMAGE_HI, 32'h0400_0000);
        sync;
        repeat (HOLD / 2) @(posedge clk);
        chk("alarm early", 1'h1, alm);
        for (int k = 0; k < 3 * HOLD && alm; k++) @(posedge clk);
        chk("alarm cleared", 1'h0, alm);
        clrok <= 1'h0;
        raise <= 1'h1;
        @(posedge clk);
        raise <= 1'h0;
        repeat (4 * HOLD) @(posedge clk);
        chk("alarm kept", 1'h1, alm);
        clrok <= 1'h1;
        for (int k = 0; k < 3 * HOLD && alm; k++) @(posedge clk);
        chk("alarm gone", 1'h0, alm);
        wr(`SRID_OFS_IMAGE_HI, 32'h0);
        wr(`SRID_OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        ia = irq;
        wr(`SRID_OFS_IRQ_MASK, 32'h7);
        repeat (2) @(posedge clk);
        chk("irq mask", 1'h1, ia ^ irq);
        rd(`SRID_OFS_IRQ_STAT);
        chk("irq alarm", 1'h1, rd_v[`SRID_IRQ_ALM_CLR]);
        repeat (2) @(posedge clk);
        chk("irq idle", 1'h0, irq);
        pin <= 1'h0;
        repeat (3) @(posedge clk);
        chk("stop on", 3'h3, {drv.power_enable, drv.dyn_brake, drv.forced_stop});
        pin <= 1'h1;
        repeat (4) @(posedge clk);
        chk("stop off", 3'h4, {drv.power_enable, drv.dyn_brake, drv.forced_stop});
        rd(`SRID_OFS_IRQ_STAT);
        chk("irq stop", 2'h3, rd_v[1:0]);
        wrap_up;
    end
endmodule
